// file: src/pms_pkg.sv
// shared constants of the serial management port and interrupt logic
`default_nettype none
package pms_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned T_CLK_NS = 5;
	localparam int unsigned MDC_HALF_NS = 200;
	localparam int unsigned MDC_HALF_CYC = (MDC_HALF_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned MDC_EDGE_MIN_NS = 160;
	localparam int unsigned LATE_IRQ_MS = 256;
	localparam int unsigned LATE_IRQ_CYC = LATE_IRQ_MS * 1000000 / T_CLK_NS;
	localparam int unsigned ACQ_MS = 2;
	localparam int unsigned ACQ_CYC = ACQ_MS * 1000000 / T_CLK_NS;
	// ****************************************
	// frame format
	// ****************************************
	localparam logic [5:0] PRE_ONES = 6'h20;
	localparam logic [3:0] HDR_LAST = 4'hc;
	localparam logic [3:0] DAT_LAST = 4'hf;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] START_BITS = 2'h1;
	localparam logic [1:0] TA_BITS = 2'h2;
	localparam logic [31:0] PRE_WORD = 32'hffffffff;
	localparam logic [6:0] FRAME_LAST = 7'h3f;
	localparam logic [6:0] TA_FIRST = 7'h2e;
	localparam logic [6:0] DAT_FIRST = 7'h30;
	// ****************************************
	// device register map
	// ****************************************
	localparam logic [4:0] REG_BCTL = 5'h00;
	localparam logic [4:0] REG_BSTAT = 5'h01;
	localparam logic [4:0] REG_ID_HI = 5'h02;
	localparam logic [4:0] REG_ID_LO = 5'h03;
	localparam logic [4:0] REG_ANADV = 5'h04;
	localparam logic [4:0] REG_ANLPA = 5'h05;
	localparam logic [4:0] REG_ANEXP = 5'h06;
	localparam logic [4:0] REG_MODE = 5'h11;
	localparam logic [4:0] REG_IRQ_SRC = 5'h1d;
	localparam logic [4:0] REG_IRQ_MASK = 5'h1e;
	localparam logic [15:0] UNIMPL_VAL = 16'hffff;
	localparam int unsigned B_RESTART = 9;
	localparam int unsigned B_ANC = 5;
	localparam int unsigned B_RFAULT = 4;
	localparam int unsigned B_LINK = 2;
	localparam int unsigned B_LPACK = 14;
	localparam int unsigned B_PDF = 4;
	localparam int unsigned B_PGRX = 1;
	localparam int unsigned B_ENERGY = 1;
	localparam int unsigned B_ALTSEL = 6;
	// interrupt flag positions, 29.x and 30.x
	localparam int unsigned F_ENERGY = 7;
	localparam int unsigned F_ANC = 6;
	localparam int unsigned F_RFAULT = 5;
	localparam int unsigned F_LINKDN = 4;
	localparam int unsigned F_LPACK = 3;
	localparam int unsigned F_PDF = 2;
	localparam int unsigned F_PGRX = 1;
	localparam logic [15:0] FLAGS_RST = 16'h0080;
	localparam logic [7:1] SRC_D_RST = 7'h48;
	// ****************************************
	// station command registers
	// ****************************************
	localparam logic [2:0] H_FRAME = 3'h0;
	localparam logic [2:0] H_WDATA = 3'h1;
	localparam logic [2:0] H_GO = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_RDATA = 3'h4;
	localparam int unsigned HF_READ = 10;
endpackage : pms_pkg
`default_nettype wire

// file: src/pms_mgmt_if.sv
// management clock and shared data line between station and transceiver
`timescale 1ns/10ps
`default_nettype none
interface pms_mgmt_if;
	logic mdc;
	logic host_mdo;
	logic host_oe_n;
	logic dev_mdo;
	logic dev_oe_n;
	logic mdio;
	// pulled-up shared line, any driver pulling low wins
	assign mdio = ~((~host_oe_n & ~host_mdo) | (~dev_oe_n & ~dev_mdo));
	modport dev_mp (input mdc, input mdio, output dev_mdo, output dev_oe_n);
	modport host_mp (output mdc, output host_mdo, output host_oe_n, input mdio);
endinterface : pms_mgmt_if
`default_nettype wire

// file: src/pms_sync3.sv
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module pms_sync3 #(
	parameter int unsigned W = 1
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// asynchronous input
	input wire logic [W-1:0] din,
	// filtered level and edges
	output var logic [W-1:0] lvl,
	output var logic [W-1:0] rise,
	output var logic [W-1:0] fall
);
	import pms_pkg::*;
	typedef struct packed {
		logic [W-1:0] f1;
		logic [W-1:0] f2;
		logic [W-1:0] f3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} pms_sync_t;
	pms_sync_t q;
	pms_sync_t n;
	if (W < 1)
	begin : g_chk
		$error("width must be at least one");
	end
	// first stage feeds only the second
	always_comb
	begin
		n = q;
		n.f1 = din;
		n.f2 = q.f1;
		n.f3 = q.f2;
		for (int i = 0; i < W; i++)
		begin
			n.rise[i] = 1'b0;
			n.fall[i] = 1'b0;
			if (q.f2[i] == q.f3[i])
			begin
				n.lvl[i] = q.f3[i];
				n.rise[i] = q.f3[i] & ~q.lvl[i];
				n.fall[i] = ~q.f3[i] & q.lvl[i];
			end
		end
		if (srst)
		begin
			n = '0;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		q <= n;
	end
	assign lvl = q.lvl;
	assign rise = q.rise;
	assign fall = q.fall;
endmodule : pms_sync3
`default_nettype wire

// file: src/pms_phy_end.sv
// transceiver end: serial management slave, registers and interrupt logic
//
// Notes on behaviour
// - registers 0-6 and 16-31 reachable
// - unimplemented registers read as ffff
// - station supplies clock, data both ways
// - clock edges 160 ns apart, 400 ns cycle
// - receiver samples data on rising clock
// - answer only frames matching own address
// - masked event pulls interrupt output low
// - primary scheme selected after reset
// - both schemes assert alike, release differs
// - energy flag, release on fall or 29
// - negotiation done, fall or 29 read
// - remote fault, fall, read 1 or 29
// - link down, release on read 1/29
// - partner ack, fall or 29 read
// - parallel fault, fall, reads, restart, link loss
// - page received, fall, reads, restart, link loss
// - late 256 ms assertion after energy drops
// - service routine should clear energy mask
// - energy status and flag start at one
// - alternate: write one rechecks, clears if released
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pms_phy_end #(
	parameter int unsigned LATE_CYC = pms_pkg::LATE_IRQ_CYC,
	parameter int unsigned ACQ_CYC = pms_pkg::ACQ_CYC,
	parameter logic [15:0] ID_HI = 16'h0a5a, // arbitrary
	parameter logic [15:0] ID_LO = 16'h5a01 // arbitrary
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// management link
	pms_mgmt_if.dev_mp mif,
	// own address
	input wire logic [4:0] phy_addr,
	// line and negotiation status, same clock
	input wire logic line_energy_raw,
	input wire logic link_up,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic lp_ack,
	input wire logic par_det_fault,
	input wire logic page_rx,
	// outputs
	output var logic irq_out_low,
	output var logic an_restart,
	output var logic line_energy_present
);
	import pms_pkg::*;
	typedef enum logic [1:0] {
		S_PRE = 2'h0,
		S_HDR = 2'h1,
		S_TA = 2'h3,
		S_DAT = 2'h2
	} pms_dst_t;
	typedef struct packed {
		pms_dst_t st;
		logic [5:0] cnt;
		logic [12:0] hdr;
		logic [15:0] sh;
		logic rd;
		logic mdo;
		logic oe_n;
		logic [15:0] ctl0;
		logic [15:0] adv4;
		logic [15:0][15:0] vend;
		logic [15:0] flags;
		logic [7:1] src_d;
		logic [31:0] acq_cnt;
		logic armed;
		logic [31:0] late_cnt;
		logic irq_n;
		logic restart;
		logic energy;
	} pms_dev_t;
	pms_dev_t q;
	pms_dev_t n;
	logic [1:0] s_lvl;
	logic [1:0] s_rise;
	logic [1:0] s_fall;
	logic mdc_r;
	logic mdc_f;
	logic mdio_l;
	logic [12:0] hdr_full;
	logic [15:0] rval;
	logic [15:0] wdat;
	logic [7:1] src;
	logic [7:1] rise;
	logic [7:1] fall;
	logic [7:1] clr;
	logic [15:0] wr29;
	logic rd1;
	logic rd6;
	logic rd29;
	logic alt;
	logic energy;
	if (LATE_CYC < 1 || ACQ_CYC < 1)
	begin : g_chk
		$error("delay counts must be at least one");
	end
	// ****************************************
	// pin sampling
	// ****************************************
	pms_sync3 #(.W(2)) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.din({mif.mdc, mif.mdio}),
		.lvl(s_lvl),
		.rise(s_rise),
		.fall(s_fall)
	);
	assign mdc_r = s_rise[1];
	assign mdc_f = s_fall[1];
	assign mdio_l = s_lvl[0];
	// ****************************************
	// frame engine and registers
	// ****************************************
	always_comb
	begin
		n = q;
		n.restart = 1'b0;
		rd1 = 1'b0;
		rd6 = 1'b0;
		rd29 = 1'b0;
		wr29 = 16'h0;
		wdat = {q.sh[14:0], mdio_l};
		hdr_full = {q.hdr[11:0], mdio_l};
		alt = q.vend[REG_MODE[3:0]][B_ALTSEL];
		energy = line_energy_raw | (q.acq_cnt != 32'h0);
		src = {energy, an_complete, remote_fault, ~link_up, lp_ack,
			par_det_fault, page_rx};
		rise = src & ~q.src_d;
		fall = ~src & q.src_d;
		// read image, status bits live
		rval = UNIMPL_VAL;
		case (hdr_full[4:0])
			REG_BCTL: rval = q.ctl0;
			REG_BSTAT:
			begin
				rval = 16'h0;
				rval[B_ANC] = an_complete;
				rval[B_RFAULT] = remote_fault;
				rval[B_LINK] = link_up;
			end
			REG_ID_HI: rval = ID_HI;
			REG_ID_LO: rval = ID_LO;
			REG_ANADV: rval = q.adv4;
			REG_ANLPA:
			begin
				rval = 16'h0;
				rval[B_LPACK] = lp_ack;
			end
			REG_ANEXP:
			begin
				rval = 16'h0;
				rval[B_PDF] = par_det_fault;
				rval[B_PGRX] = page_rx;
			end
			REG_MODE:
			begin
				rval = q.vend[REG_MODE[3:0]];
				rval[B_ENERGY] = energy;
			end
			REG_IRQ_SRC: rval = q.flags;
			default:
			begin
				if (hdr_full[4])
				begin
					rval = q.vend[hdr_full[3:0]];
				end
			end
		endcase
		unique case (q.st)
			S_PRE:
			begin
				if (mdc_r)
				begin
					if (mdio_l)
					begin
						n.cnt = (q.cnt == PRE_ONES) ? q.cnt : q.cnt + 6'h1;
					end
					else if (q.cnt == PRE_ONES)
					begin
						n.st = S_HDR;
						n.cnt = 6'h0;
					end
					else
					begin
						n.cnt = 6'h0;
					end
				end
			end
			S_HDR:
			begin
				if (mdc_r)
				begin
					n.hdr = hdr_full;
					n.cnt = q.cnt + 6'h1;
					// start bit, opcode, phy and register address: 13 rises
					if (q.cnt[3:0] == HDR_LAST)
					begin
						n.st = S_PRE;
						n.cnt = 6'h0;
						if (hdr_full[12] && hdr_full[9:5] == phy_addr
							&& (hdr_full[11:10] == OP_RD
							|| hdr_full[11:10] == OP_WR))
						begin
							n.st = S_TA;
							n.rd = (hdr_full[11:10] == OP_RD);
							if (hdr_full[11:10] == OP_RD)
							begin
								n.sh = rval;
								rd1 = (hdr_full[4:0] == REG_BSTAT);
								rd6 = (hdr_full[4:0] == REG_ANEXP);
								rd29 = (hdr_full[4:0] == REG_IRQ_SRC);
							end
						end
					end
				end
			end
			S_TA:
			begin
				if (mdc_f && q.rd && q.cnt == 6'h1)
				begin
					n.mdo = 1'b0;
					n.oe_n = 1'b0;
				end
				if (mdc_r)
				begin
					n.cnt = q.cnt + 6'h1;
					if (q.cnt == 6'h1)
					begin
						n.st = S_DAT;
						n.cnt = 6'h0;
					end
				end
			end
			S_DAT:
			begin
				if (mdc_f && q.rd)
				begin
					n.mdo = q.sh[15];
				end
				if (mdc_r)
				begin
					n.sh = q.rd ? {q.sh[14:0], 1'b0} : wdat;
					n.cnt = q.cnt + 6'h1;
					if (q.cnt[3:0] == DAT_LAST)
					begin
						n.st = S_PRE;
						n.cnt = 6'h0;
						n.oe_n = 1'b1;
						n.mdo = 1'b1;
						if (!q.rd)
						begin
							case (q.hdr[4:0])
								REG_BCTL:
								begin
									n.ctl0 = wdat;
									n.ctl0[B_RESTART] = 1'b0;
									n.restart = wdat[B_RESTART];
								end
								REG_ANADV: n.adv4 = wdat;
								REG_IRQ_SRC: wr29 = wdat;
								default:
								begin
									if (q.hdr[4])
									begin
										n.vend[q.hdr[3:0]] = wdat;
									end
								end
							endcase
						end
					end
				end
			end
		endcase
		// ****************************************
		// interrupt flags
		// ****************************************
		if (alt)
		begin
			clr = wr29[7:1] & ~src;
		end
		else
		begin
			clr = fall;
			clr[F_LINKDN] = 1'b0;
			clr = clr | {7{rd29}};
			clr[F_RFAULT] = clr[F_RFAULT] | rd1;
			clr[F_LINKDN] = clr[F_LINKDN] | rd1;
			clr[F_PDF] = clr[F_PDF] | rd6 | n.restart | rise[F_LINKDN];
			clr[F_PGRX] = clr[F_PGRX] | rd6 | n.restart | rise[F_LINKDN];
		end
		// a new event beats a clear in the same cycle
		n.flags[7:1] = (q.flags[7:1] & ~clr) | rise;
		n.src_d = src;
		n.energy = energy;
		n.acq_cnt = (q.acq_cnt != 32'h0) ? q.acq_cnt - 32'h1 : 32'h0;
		if (!alt && q.vend[REG_IRQ_MASK[3:0]][F_ENERGY] && clr[F_ENERGY]
			&& src[F_ENERGY] && !rise[F_ENERGY])
		begin
			n.armed = 1'b1;
		end
		n.late_cnt = (q.late_cnt != 32'h0) ? q.late_cnt - 32'h1 : 32'h0;
		if (fall[F_ENERGY] && q.armed)
		begin
			n.armed = 1'b0;
			n.late_cnt = LATE_CYC;
		end
		// mask gating, registered so the pin never glitches
		n.irq_n = ~(|(n.flags[7:1] & n.vend[REG_IRQ_MASK[3:0]][7:1])
			| (n.late_cnt != 32'h0));
		if (srst)
		begin
			n = '0;
			n.st = S_PRE;
			n.oe_n = 1'b1;
			n.mdo = 1'b1;
			n.flags = FLAGS_RST;
			n.src_d = SRC_D_RST;
			n.acq_cnt = ACQ_CYC;
			n.irq_n = 1'b1;
			n.energy = 1'b1;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		q <= n;
	end
	assign mif.dev_mdo = q.mdo;
	assign mif.dev_oe_n = q.oe_n;
	assign irq_out_low = q.irq_n;
	assign an_restart = q.restart;
	assign line_energy_present = q.energy;
endmodule : pms_phy_end
`default_nettype wire

// file: src/pms_station_end.sv
// station end: drives the management clock and runs one frame per command
`timescale 1ns/10ps
`default_nettype none
module pms_station_end #(
	parameter int unsigned HALF_CYC = pms_pkg::MDC_HALF_CYC
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// management link
	pms_mgmt_if.host_mp mif,
	// command port
	input wire logic [2:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output var logic [15:0] cmd_rdata
);
	import pms_pkg::*;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_LOW = 2'h1,
		H_HIGH = 2'h3
	} pms_hst_t;
	typedef struct packed {
		pms_hst_t st;
		logic [15:0] tcnt;
		logic [6:0] bcnt;
		logic [63:0] sh;
		logic rd;
		logic [10:0] frame;
		logic [15:0] wdat;
		logic [15:0] rdat;
		logic mdc;
		logic mdo;
		logic oe_n;
		logic [15:0] rdata;
	} pms_host_t;
	pms_host_t q;
	pms_host_t n;
	logic mdio_l;
	logic [6:0] nb;
	logic [63:0] word;
	// edges closer than the minimum would break the far end
	if (HALF_CYC * T_CLK_NS < MDC_EDGE_MIN_NS || HALF_CYC > 16'hffff)
	begin : g_chk
		$error("half period too short or too long");
	end
	pms_sync3 #(.W(1)) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.din(mif.mdio),
		.lvl(mdio_l),
		.rise(),
		.fall()
	);
	// ****************************************
	// command registers and frame sequencer
	// ****************************************
	always_comb
	begin
		n = q;
		nb = q.bcnt + 7'h1;
		word = {PRE_WORD, START_BITS, q.frame[HF_READ] ? OP_RD : OP_WR,
			q.frame[4:0], q.frame[9:5], TA_BITS, q.wdat};
		n.rdata = 16'h0;
		if (cmd_rd)
		begin
			unique case (cmd_addr)
				H_FRAME: n.rdata = {5'h0, q.frame};
				H_WDATA: n.rdata = q.wdat;
				H_STATUS: n.rdata = {15'h0, q.st != H_IDLE};
				H_RDATA: n.rdata = q.rdat;
				default: n.rdata = 16'h0;
			endcase
		end
		if (cmd_wr && q.st == H_IDLE)
		begin
			if (cmd_addr == H_FRAME)
			begin
				n.frame = cmd_wdata[10:0];
			end
			if (cmd_addr == H_WDATA)
			begin
				n.wdat = cmd_wdata;
			end
		end
		unique case (q.st)
			H_IDLE:
			begin
				if (cmd_wr && cmd_addr == H_GO)
				begin
					n.st = H_LOW;
					n.sh = word;
					n.rd = q.frame[HF_READ];
					n.mdo = word[63];
					n.oe_n = 1'b0;
					n.bcnt = 7'h0;
					n.tcnt = 16'h0;
				end
			end
			H_LOW:
			begin
				n.tcnt = q.tcnt + 16'h1;
				if (q.tcnt == 16'(HALF_CYC - 1))
				begin
					n.st = H_HIGH;
					n.tcnt = 16'h0;
					n.mdc = 1'b1;
					if (q.rd && q.bcnt >= DAT_FIRST)
					begin
						n.rdat = {q.rdat[14:0], mdio_l};
					end
				end
			end
			H_HIGH:
			begin
				n.tcnt = q.tcnt + 16'h1;
				if (q.tcnt == 16'(HALF_CYC - 1))
				begin
					n.tcnt = 16'h0;
					n.mdc = 1'b0;
					if (q.bcnt == FRAME_LAST)
					begin
						n.st = H_IDLE;
						n.oe_n = 1'b1;
						n.mdo = 1'b1;
					end
					else
					begin
						n.st = H_LOW;
						n.bcnt = nb;
						n.sh = {q.sh[62:0], 1'b0};
						n.mdo = q.sh[62];
						n.oe_n = q.rd && nb >= TA_FIRST;
					end
				end
			end
		endcase
		if (srst)
		begin
			n = '0;
			n.st = H_IDLE;
			n.oe_n = 1'b1;
			n.mdo = 1'b1;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		q <= n;
	end
	assign mif.mdc = q.mdc;
	assign mif.host_mdo = q.mdo;
	assign mif.host_oe_n = q.oe_n;
	assign cmd_rdata = q.rdata;
endmodule : pms_station_end
`default_nettype wire

// file: test/pms_link_asserts.sv
// concurrent checks on the management link between station and transceiver
`timescale 1ns/10ps
`default_nettype none
module pms_link_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// link signals
	input wire logic mdc,
	input wire logic host_mdo,
	input wire logic host_oe_n,
	input wire logic dev_mdo,
	input wire logic dev_oe_n,
	input wire logic mdio
);
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// ****************************************
	// edge spacing and drive length counters
	// ****************************************
	logic [7:0] gap_reg;
	logic [7:0] per_reg;
	logic [11:0] drv_reg;
	// edge counters saturate so a paused clock never wraps into a false gap
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			gap_reg <= 8'hff;
			per_reg <= 8'hff;
			drv_reg <= 12'h000;
		end
		else
		begin
			gap_reg <= $changed(mdc) ? 8'h00 : gap_reg + {7'h00, ~&gap_reg};
			per_reg <= $rose(mdc) ? 8'h00 : per_reg + {7'h00, ~&per_reg};
			drv_reg <= dev_oe_n ? 12'h000 : drv_reg + 12'h001;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	property p_no_clash;
		!(!host_oe_n && !dev_oe_n);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive the data line");
	property p_rel_idle;
		$fell(srst) |-> host_oe_n && dev_oe_n && !mdc;
	endproperty
	a_rel_idle: assert property (p_rel_idle)
		else $error("link not idle after reset");
	property p_edge_gap;
		$changed(mdc) |-> gap_reg >= 8'd31;
	endproperty
	a_edge_gap: assert property (p_edge_gap)
		else $error("clock edges too close");
	property p_cycle;
		$rose(mdc) |-> per_reg >= 8'd79;
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("clock cycle too short");
	property p_dev_setup;
		!dev_oe_n && $changed(dev_mdo) |-> !mdc;
	endproperty
	a_dev_setup: assert property (p_dev_setup)
		else $error("device data moved while clock high");
	property p_host_setup;
		!host_oe_n && $changed(host_mdo) |-> !mdc;
	endproperty
	a_host_setup: assert property (p_host_setup)
		else $error("station data moved while clock high");
	property p_line_dev;
		!dev_oe_n |-> mdio == dev_mdo;
	endproperty
	a_line_dev: assert property (p_line_dev)
		else $error("line differs from device data");
	property p_ta_zero;
		$fell(dev_oe_n) |-> !dev_mdo && !mdc;
	endproperty
	a_ta_zero: assert property (p_ta_zero)
		else $error("turnaround not driven low");
	property p_start_pre;
		$fell(host_oe_n) |-> host_mdo && !mdc;
	endproperty
	a_start_pre: assert property (p_start_pre)
		else $error("frame not opened with preamble");
	property p_drv_len;
		!dev_oe_n |-> drv_reg < 12'd1400;
	endproperty
	a_drv_len: assert property (p_drv_len)
		else $error("device drives past read data");
endmodule : pms_link_chk
`default_nettype wire

// file: test/phy_mgmt_serial_irq_tb.sv
// bench joining station end and transceiver end over one management link
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_serial_irq_tb;
	import pms_pkg::*;
	// shortened timers keep the run small
	localparam int unsigned LATE = 100;
	localparam int unsigned ACQ = 50;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [4:0] phy_addr = 5'h00;
	logic [2:0] cmd_addr = 3'h0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [15:0] cmd_rdata;
	// event sources by flag bit; bit 4 is link loss
	logic [7:1] ev = 7'h00;
	logic link_up;
	logic irq_out_low;
	logic an_restart;
	logic line_energy_present;
	logic [15:0] rv;
	logic [15:0] wd;
	logic [4:0] ra;
	int num_errors = 0;
	int comparisons = 0;
	int restarts = 0;
	int n;
	assign link_up = ~ev[4];
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (an_restart === 1'b1)
			restarts++;
	pms_mgmt_if i_pms_mgmt_if ();
	pms_station_end i_pms_station_end (.clk_sys(clk_sys), .srst(srst),
		.mif(i_pms_mgmt_if.host_mp), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_rdata(cmd_rdata));
	pms_phy_end #(.LATE_CYC(LATE), .ACQ_CYC(ACQ)) i_pms_phy_end (
		.clk_sys(clk_sys), .srst(srst), .mif(i_pms_mgmt_if.dev_mp),
		.phy_addr(phy_addr), .line_energy_raw(ev[7]), .link_up(link_up),
		.an_complete(ev[6]), .remote_fault(ev[5]), .lp_ack(ev[3]),
		.par_det_fault(ev[2]), .page_rx(ev[1]), .irq_out_low(irq_out_low),
		.an_restart(an_restart), .line_energy_present(line_energy_present));
	pms_link_chk i_pms_link_chk (.clk_sys(clk_sys), .srst(srst),
		.mdc(i_pms_mgmt_if.mdc), .host_mdo(i_pms_mgmt_if.host_mdo),
		.host_oe_n(i_pms_mgmt_if.host_oe_n), .dev_mdo(i_pms_mgmt_if.dev_mdo),
		.dev_oe_n(i_pms_mgmt_if.dev_oe_n), .mdio(i_pms_mgmt_if.mdio));
	// ****************************************
	// tasks
	// ****************************************
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [15:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic chkirq(input logic e);
		chk("irq_out_low", 16'(irq_out_low), 16'(e));
	endtask : chkirq
	task automatic waitc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask : waitc
	task automatic setev(input int i, input logic v);
		@(posedge clk_sys);
		ev[i] <= v;
		waitc(6);
	endtask : setev
	task automatic hw(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
	endtask : hw
	task automatic hr(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk_sys);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask : hr
	// one whole frame; busy polled under a bound
	task automatic frame(input logic [4:0] pa, r, input logic rd,
		input logic [15:0] w, output logic [15:0] d);
		int k;
		hw(H_FRAME, {5'h00, rd, r, pa});
		hw(H_WDATA, w);
		hw(H_GO, 16'h0000);
		k = 0;
		do
		begin
			hr(H_STATUS, d);
			k++;
		end
		while (d[0] !== 1'b0 && k < 4000);
		if (k >= 4000)
		begin
			num_errors++;
			$display("[ERR] frame busy expected 0 seen %b", d[0]);
			test_done();
		end
		else
			hr(H_RDATA, d);
	endtask : frame
	task automatic mrd(input logic [4:0] r, output logic [15:0] d);
		frame(phy_addr, r, 1'b1, 16'h0000, d);
	endtask : mrd
	task automatic mwr(input logic [4:0] r, input logic [15:0] w);
		logic [15:0] d;
		frame(phy_addr, r, 1'b0, w, d);
	endtask : mwr
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		void'($urandom(32'had1575b7));
		@(posedge clk_sys);
		phy_addr <= 5'($urandom());
		repeat (15) @(posedge clk_sys);
		srst <= 1'b0;
		waitc(1);
		chk("energy", 16'(line_energy_present), 16'h0001);
		chkirq(1'b1);
		waitc(ACQ + 10);
		chk("energy", 16'(line_energy_present), 16'h0000);
		mrd(REG_IRQ_SRC, rv);
		chk("flags", rv, 16'h0000);
		mrd(REG_MODE, rv);
		chk("alt sel", 16'(rv[B_ALTSEL]), 16'h0000);
		$display("reset test done");
		ra = 5'd7 + 5'($urandom_range(7));
		mrd(ra, rv);
		chk("unimpl", rv, UNIMPL_VAL);
		mrd(5'd15, rv);
		chk("unimpl", rv, UNIMPL_VAL);
		ra = 5'd18 + 5'($urandom_range(10));
		wd = 16'($urandom());
		mwr(ra, wd);
		frame(phy_addr ^ (5'h01 << $urandom_range(4)), ra, 1'b0, ~wd, rv);
		mrd(ra, rv);
		chk("vendor", rv, wd);
		$display("map test done");
		setev(6, 1'b1);
		chkirq(1'b1);
		setev(6, 1'b0);
		mwr(REG_IRQ_MASK, 16'h00fe);
		for (int i = 7; i >= 1; i--)
			if (i != 4)
			begin
				setev(i, 1'b1);
				chkirq(1'b0);
				setev(i, 1'b0);
				chkirq(1'b1);
			end
		$display("edge test done");
		setev(4, 1'b1);
		setev(5, 1'b1);
		chkirq(1'b0);
		mrd(REG_BSTAT, rv);
		chk("bstat", rv, 16'h0010);
		chkirq(1'b1);
		setev(4, 1'b0);
		setev(5, 1'b0);
		setev(6, 1'b1);
		setev(3, 1'b1);
		mrd(REG_IRQ_SRC, rv);
		chk("flags", rv, 16'h0048);
		chkirq(1'b1);
		setev(6, 1'b0);
		setev(3, 1'b0);
		setev(2, 1'b1);
		mrd(REG_ANEXP, rv);
		chk("anexp", rv, 16'h0010);
		chkirq(1'b1);
		setev(2, 1'b0);
		setev(1, 1'b1);
		mwr(REG_BCTL, 16'h0200);
		chkirq(1'b1);
		chk("restart", 16'(restarts), 16'h0001);
		setev(1, 1'b0);
		$display("read release test done");
		setev(7, 1'b1);
		mrd(REG_IRQ_SRC, rv);
		chk("flags", rv, 16'h0080);
		chkirq(1'b1);
		@(posedge clk_sys);
		ev[7] <= 1'b0;
		n = 0;
		for (int k = 0; k < LATE + 40; k++)
		begin
			@(posedge clk_sys);
			if (irq_out_low === 1'b0)
				n++;
		end
		chk("late", 16'(n >= LATE - 2 && n <= LATE + 4), 16'h0001);
		mwr(REG_IRQ_MASK, 16'h007e);
		$display("late test done");
		mwr(REG_MODE, 16'h0040);
		setev(6, 1'b1);
		chkirq(1'b0);
		mwr(REG_IRQ_SRC, 16'h0040);
		chkirq(1'b0);
		setev(6, 1'b0);
		chkirq(1'b0);
		mwr(REG_IRQ_SRC, 16'h0040);
		chkirq(1'b1);
		$display("alternate test done");
		test_done();
	end
endmodule : phy_mgmt_serial_irq_tb
`default_nettype wire
